/* hw/frame_status_consts.svh */
// Purpose: named offsets, field positions, codes and reset values
// Assumes: 10-bit byte register address, 8-bit register data
// Notes:   definitions only, shared by the frame/status block
`ifndef FRAME_STATUS_CONSTS_SVH
`define FRAME_STATUS_CONSTS_SVH

// register offsets
`define OFF_FRAME_CHAR   10'h207
`define OFF_LINK_STATUS  10'h208
`define OFF_IRQ_STATUS   10'h2f0
`define OFF_IRQ_MASK     10'h2f1
`define OFF_LINK_CTRL    10'h2f2

// link status field positions
`define BIT_LINK_UP      6
`define BIT_SYNC_LEVEL   5
`define BIT_REALIGN      4
`define BIT_MF_PHASE     3
`define BIT_PLL_LOCK     2

// link control field positions
`define BIT_CTRL_ENABLE  0
`define BIT_CTRL_8B10B   1

// end-of-frame select codes
`define SEL_K28_7        2'h0
`define SEL_K28_1        2'h1
`define SEL_K28_5        2'h2

// control character codes (data byte of the k character)
`define CODE_K28_7       8'hfc
`define CODE_K28_1       8'h3c
`define CODE_K28_5       8'hbc

// reset values
`define RST_BYTE         8'h00
`define RST_SEL          2'h0
`define RST_CTRL         2'h2

`endif

/* hw/frame_status_pkg.sv */
// Purpose: types shared by the frame/status block and its users
// Assumes: constants live in frame_status_consts.svh
// Notes:   no numbers here beyond type widths
package frame_status_pkg;

  typedef logic [9:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;

  // one line character before coding
  typedef struct packed {
    logic      is_k;
    reg_byte_t code;
  } char_t;

  // incoming character with its framing marks
  typedef struct packed {
    char_t ch;
    logic  valid;
    logic  frame_end;
    logic  replace_ok;
  } char_in_t;

  // multiframe phase tracking after link enable
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ARMED,
    PH_DONE
  } phase_state_t;

endpackage

/* hw/bit_sync.sv */
// Purpose: two-stage (or deeper) synchroniser for asynchronous levels
// Assumes: each bit is an independent slow level
// Notes:   only the last stage is meant to be read by logic
`timescale 1ns/1ps

module bit_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // refuse shapes the chain cannot serve
  initial begin
    if (WIDTH < 1 || STAGES < 2) begin
      $error("bit_sync: WIDTH >= 1 and STAGES >= 2 needed");
    end
  end

  logic [WIDTH-1:0] chain_r [STAGES];
  logic [WIDTH-1:0] chain_nxt [STAGES];

  // shift the chain by one stage
  always_comb begin
    chain_nxt[0] = d;
    for (int i = 1; i < STAGES; i++) begin
      chain_nxt[i] = chain_r[i-1];
    end
  end

  // register the chain, cleared at reset
  always_ff @(posedge clk) begin
    for (int i = 0; i < STAGES; i++) begin
      if (!rst_n) begin
        chain_r[i] <= '0;
      end else begin
        chain_r[i] <= chain_nxt[i];
      end
    end
  end

  assign q = chain_r[STAGES-1];

endmodule

/* hw/frame_status_top.sv */
// Purpose: end-of-frame character insertion and link status reporting
// Assumes: 20 MHz clk, synchronous active-low reset, plain register port
// Notes:   sync and pll lock arrive from pins and are synchronised
//
// Functional notes
// - a 2-bit select picks K28.7 (0, reset), K28.1 (1), K28.5 (2), 3 reserved.
// - the chosen char replaces a permitted frame end, in 8b/10b coding only.
// - status bit 6 reads 1 while the link is up and enabled, and 0 otherwise.
// - status bit 5 shows the sync level: 0 asserted, 1 released.
// - status bit 4 is set by a sysref phase shift and cleared by writing 1.
// - status bit 3 marks the first sysref after enable, cleared by writing 1.
// - status bit 2 reads 1 while the serializer pll is locked.
`timescale 1ns/1ps
`include "frame_status_consts.svh"

module frame_status_top #(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // register port
  input  wire frame_status_pkg::reg_addr_t reg_addr,
  input  wire frame_status_pkg::reg_byte_t reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output frame_status_pkg::reg_byte_t     reg_rdata,
  // status sources
  input  wire logic                       sync_pin_n,
  input  wire logic                       pll_lock_pin,
  input  wire logic                       link_up_in,
  input  wire logic                       sysref_realign,
  input  wire logic                       sysref_event,
  // character stream
  input  wire frame_status_pkg::char_in_t  char_in,
  output frame_status_pkg::char_t         char_out,
  output logic                            char_out_valid,
  // control and interrupt
  output logic                            link_enable,
  output logic                            coding_8b10b,
  output logic                            irq
);
  import frame_status_pkg::*;

  // refuse a synchroniser too short to be safe
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("frame_status_top: SYNC_STAGES must be at least 2");
    end
  end

  // synchronised pin levels
  logic [1:0] pin_q;
  logic       sync_level;
  logic       pll_locked;

  // bring asynchronous pins into the clock domain
  bit_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sync_pin_n, pll_lock_pin}),
    .q     (pin_q)
  );

  assign sync_level = pin_q[1]; // high while sync released
  assign pll_locked = pin_q[0];

  // ------------------------------------------------------------
  // address decode
  logic hit_frame;
  logic hit_status;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_ctrl;

  // decode the register port
  always_comb begin
    hit_frame    = (reg_addr == `OFF_FRAME_CHAR);
    hit_status   = (reg_addr == `OFF_LINK_STATUS);
    hit_irq_st   = (reg_addr == `OFF_IRQ_STATUS);
    hit_irq_mask = (reg_addr == `OFF_IRQ_MASK);
    hit_ctrl     = (reg_addr == `OFF_LINK_CTRL);
  end

  // ------------------------------------------------------------
  // configuration registers
  logic [1:0] frame_end_char_select_r;
  logic [1:0] frame_end_char_select_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  reg_byte_t  mask_r;
  reg_byte_t  mask_nxt;

  // software writes to select, control and mask
  always_comb begin
    frame_end_char_select_nxt = frame_end_char_select_r;
    ctrl_nxt                  = ctrl_r;
    mask_nxt                  = mask_r;
    // select only taken while the link is disabled
    if (reg_wr && hit_frame && !ctrl_r[`BIT_CTRL_ENABLE]) begin
      frame_end_char_select_nxt = reg_wdata[1:0];
    end
    if (reg_wr && hit_ctrl) begin
      ctrl_nxt = reg_wdata[1:0];
    end
    if (reg_wr && hit_irq_mask) begin
      mask_nxt = reg_wdata;
    end
  end

  // register configuration, select resets to K28.7
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_end_char_select_r <= `RST_SEL;
      ctrl_r                  <= `RST_CTRL;
      mask_r                  <= `RST_BYTE;
    end else begin
      frame_end_char_select_r <= frame_end_char_select_nxt;
      ctrl_r                  <= ctrl_nxt;
      mask_r                  <= mask_nxt;
    end
  end

  assign link_enable  = ctrl_r[`BIT_CTRL_ENABLE];
  assign coding_8b10b = ctrl_r[`BIT_CTRL_8B10B];

  // ------------------------------------------------------------
  // multiframe phase tracking
  phase_state_t phase_r;
  phase_state_t phase_nxt;
  logic         ev_mf_phase;

  // arm on enable, first sysref after that marks the phase
  always_comb begin
    phase_nxt   = phase_r;
    ev_mf_phase = 1'b0;
    unique case (phase_r)
      PH_IDLE: begin
        if (link_enable) begin
          phase_nxt = PH_ARMED;
        end
      end
      PH_ARMED: begin
        if (!link_enable) begin
          phase_nxt = PH_IDLE;
        end else if (sysref_event) begin
          ev_mf_phase = 1'b1; // first sysref after enable
          phase_nxt   = PH_DONE;
        end
      end
      PH_DONE: begin
        if (!link_enable) begin
          phase_nxt = PH_IDLE;
        end
      end
    endcase
  end

  // register the phase state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ------------------------------------------------------------
  // sticky flags and interrupt status
  logic      realign_r;
  logic      realign_nxt;
  logic      mf_phase_r;
  logic      mf_phase_nxt;
  logic      pll_prev_r;
  logic      pll_prev_nxt;
  reg_byte_t irq_st_r;
  reg_byte_t irq_st_nxt;
  reg_byte_t events;
  reg_byte_t st_clear;
  reg_byte_t irq_clear;

  // events set, write-one clears, a set wins over a clear
  always_comb begin
    events                 = '0;
    events[`BIT_REALIGN]   = sysref_realign;
    events[`BIT_MF_PHASE]  = ev_mf_phase;
    events[`BIT_PLL_LOCK]  = pll_prev_r & ~pll_locked; // lock lost
    st_clear  = (reg_wr && hit_status) ? reg_wdata : `RST_BYTE;
    irq_clear = (reg_wr && hit_irq_st) ? reg_wdata : `RST_BYTE;
    // writing 0 leaves each flag as it was
    realign_nxt  = sysref_realign |
                   (realign_r & ~st_clear[`BIT_REALIGN]);
    mf_phase_nxt = ev_mf_phase |
                   (mf_phase_r & ~st_clear[`BIT_MF_PHASE]);
    pll_prev_nxt = pll_locked;
    irq_st_nxt   = events | (irq_st_r & ~irq_clear);
  end

  // register flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      realign_r  <= 1'b0;
      mf_phase_r <= 1'b0;
      pll_prev_r <= 1'b0;
      irq_st_r   <= `RST_BYTE;
    end else begin
      realign_r  <= realign_nxt;
      mf_phase_r <= mf_phase_nxt;
      pll_prev_r <= pll_prev_nxt;
      irq_st_r   <= irq_st_nxt;
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irq_st_r & mask_r);

  // ------------------------------------------------------------
  // read path
  reg_byte_t status_view;
  reg_byte_t rdata_r;
  reg_byte_t rdata_nxt;

  // assemble the link status byte and pick the read answer
  always_comb begin
    status_view                  = '0;
    // live bits come from sources, never from writes
    status_view[`BIT_LINK_UP]    = link_up_in & link_enable;
    status_view[`BIT_SYNC_LEVEL] = sync_level;
    status_view[`BIT_REALIGN]    = realign_r;
    status_view[`BIT_MF_PHASE]   = mf_phase_r;
    status_view[`BIT_PLL_LOCK]   = pll_locked;
    rdata_nxt = `RST_BYTE;
    if (reg_rd) begin
      if (hit_frame) begin
        rdata_nxt = {6'h00, frame_end_char_select_r};
      end else if (hit_status) begin
        rdata_nxt = status_view;
      end else if (hit_irq_st) begin
        rdata_nxt = irq_st_r;
      end else if (hit_irq_mask) begin
        rdata_nxt = mask_r;
      end else if (hit_ctrl) begin
        rdata_nxt = {6'h00, ctrl_r};
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= `RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // end-of-frame character insertion
  char_t eof_char;
  logic  eof_known;
  logic  do_replace;
  char_t out_r;
  char_t out_nxt;
  logic  out_valid_r;
  logic  out_valid_nxt;

  // map the select to its control character
  always_comb begin
    eof_char.is_k = 1'b1;
    eof_char.code = `CODE_K28_7;
    eof_known     = 1'b1;
    unique case (frame_end_char_select_r)
      `SEL_K28_7: eof_char.code = `CODE_K28_7;
      `SEL_K28_1: eof_char.code = `CODE_K28_1;
      `SEL_K28_5: eof_char.code = `CODE_K28_5;
      default:    eof_known     = 1'b0; // reserved, no insertion
    endcase
  end

  // replace only at a permitted frame end in 8b/10b coding
  always_comb begin
    do_replace = char_in.valid & char_in.frame_end & char_in.replace_ok &
                 coding_8b10b & eof_known;
    out_valid_nxt = char_in.valid & link_enable;
    out_nxt       = char_in.ch;
    if (do_replace) begin
      out_nxt = eof_char;
    end
  end

  // register the outgoing character
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_r       <= '0;
      out_valid_r <= 1'b0;
    end else begin
      out_r       <= out_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  assign char_out       = out_r;
  assign char_out_valid = out_valid_r;

endmodule

/* dv/frame_status_asserts.sv */
// Purpose: port assertions for frame_status_top
// Assumes: one clock, synchronous active-low reset
// Notes:   the end char select is mirrored from register writes
`timescale 1ns/1ps
`include "frame_status_consts.svh"
module frame_status_asserts
  import frame_status_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // register port
  input wire frame_status_pkg::reg_addr_t reg_addr,
  input wire frame_status_pkg::reg_byte_t reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire frame_status_pkg::reg_byte_t reg_rdata,
  // status sources
  input wire logic                        sync_pin_n,
  input wire logic                        pll_lock_pin,
  input wire logic                        link_up_in,
  input wire logic                        sysref_realign,
  // stream and control
  input wire frame_status_pkg::char_in_t  char_in,
  input wire frame_status_pkg::char_t     char_out,
  input wire logic                        char_out_valid,
  input wire logic                        link_enable,
  input wire logic                        coding_8b10b
);
  logic [1:0] sel_r;
  logic [7:0] eoc;
  logic       rd_st;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // status read strobe and expected end code
  assign rd_st = reg_rd && reg_addr == `OFF_LINK_STATUS;
  assign eoc = sel_r == 2'h1 ? `CODE_K28_1 :
               sel_r == 2'h2 ? `CODE_K28_5 : `CODE_K28_7;
  // select copy, writes ignored while enabled
  always_ff @(posedge clk) begin
    if (!rst_n)
      sel_r <= `RST_SEL;
    else if (reg_wr && reg_addr == `OFF_FRAME_CHAR && !link_enable)
      sel_r <= reg_wdata[1:0];
  end
  sequence end_req;
    char_in.valid && char_in.frame_end && char_in.replace_ok
    && coding_8b10b && link_enable && sel_r != 2'h3;
  endsequence
  sequence clr_rl;
    reg_wr && reg_addr == `OFF_LINK_STATUS && reg_wdata[4] && !sysref_realign;
  endsequence
  a_end_char: assert property (
    end_req |=> char_out == {1'b1, eoc}) else $error("end char wrong");
  a_pass_thru: assert property (
    char_in.valid && link_enable && !(char_in.frame_end &&
    char_in.replace_ok && coding_8b10b) |=> char_out == $past(char_in.ch))
    else $error("char altered");
  a_out_valid: assert property (
    char_out_valid == $past(char_in.valid && link_enable))
    else $error("char valid wrong");
  a_link_up: assert property (
    rd_st |=> reg_rdata[6] == $past(link_up_in && link_enable))
    else $error("link up bit wrong");
  a_sync_bit: assert property (
    $stable(sync_pin_n)[*4] ##0 rd_st |=> reg_rdata[5] == $past(sync_pin_n))
    else $error("sync bit wrong");
  a_pll_bit: assert property (
    $stable(pll_lock_pin)[*4] ##0 rd_st |=>
    reg_rdata[2] == $past(pll_lock_pin))
    else $error("pll bit wrong");
  a_realign_set: assert property (
    sysref_realign ##1 !reg_wr ##1 rd_st |=> reg_rdata[4])
    else $error("realign not set");
  a_w1c_clear: assert property (
    clr_rl ##1 !sysref_realign ##1 rd_st |=> !reg_rdata[4])
    else $error("realign not cleared");
  a_zero_keep: assert property (
    rd_st ##1 (reg_rdata[4] && !reg_wr) ##1 (reg_wr &&
    reg_addr == `OFF_LINK_STATUS && !reg_wdata[4]) ##1 !reg_wr ##1 rd_st
    |=> reg_rdata[4]) else $error("flag lost");
endmodule
bind frame_status_top frame_status_asserts
  #(.SYNC_STAGES(SYNC_STAGES)) chk_u (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sync_pin_n, .pll_lock_pin, .link_up_in, .sysref_realign, .char_in,
  .char_out, .char_out_valid, .link_enable, .coding_8b10b);

/* dv/rx_model.sv */
// Purpose: far-side receiver holding the sync line
// Assumes: same clock as the block
// Notes:   sync released on the first control char received
`timescale 1ns/1ps
module rx_model (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // characters from the block
  input  wire frame_status_pkg::char_t rx_ch,
  input  wire logic                    rx_valid,
  // forced loss of alignment
  input  wire logic                    hold_sync,
  output logic                         sync_n
);
  // sync asserted low until a control char arrives
  always_ff @(posedge clk) begin
    if (!rst_n || hold_sync)
      sync_n <= 1'b0;
    else if (rx_valid && rx_ch.is_k)
      sync_n <= 1'b1;
  end
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench for frame_status_top
// Assumes: 20 MHz clock, reset held 20 cycles
// Notes:   reads and chars checked against queued notes
`timescale 1ns/1ps
`include "frame_status_consts.svh"
module tb;
  import frame_status_pkg::*;
  logic      clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic      pll = 1, lup = 0, realign = 0, sref = 0, hold = 0;
  logic      cval, en, c8, irq, sync_n;
  reg_addr_t addr = '0;
  reg_byte_t wdata = '0, rdata;
  char_in_t  cin = '0;
  char_t     cout;
  int        fail_count = 0, check_count = 0, seed = 67445;
  reg_byte_t exp_rd[$];
  char_t     exp_ch[$];
  always #25 clk = ~clk;
  frame_status_top dut_u (.clk, .rst_n, .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr, .reg_rd, .reg_rdata(rdata), .sync_pin_n(sync_n),
    .pll_lock_pin(pll), .link_up_in(lup), .sysref_realign(realign),
    .sysref_event(sref), .char_in(cin), .char_out(cout),
    .char_out_valid(cval), .link_enable(en), .coding_8b10b(c8), .irq);
  rx_model rx_u (.clk, .rst_n, .rx_ch(cout), .rx_valid(cval),
    .hold_sync(hold), .sync_n);
  task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one register cycle, reads note the expected byte
  task automatic bus(logic w, reg_addr_t a, reg_byte_t d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_rd.push_back(d);
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask
  // one random data char, rep[8] set means replaced by rep
  task automatic send(logic fe, logic ok, logic [8:0] rep, logic out);
    char_t c;
    c = {1'b0, 8'($random(seed))};
    @(posedge clk);
    cin <= {c, 1'b1, fe, ok};
    if (out) exp_ch.push_back(rep[8] ? rep : c);
    @(posedge clk);
    cin <= '0;
  endtask
  task automatic pulse(logic e, logic r);
    @(posedge clk);
    sref <= e;
    realign <= r;
    @(posedge clk);
    sref <= 0;
    realign <= 0;
  endtask
  function automatic logic [8:0] eoc(int s);
    case (s)
      0: return {1'b1, `CODE_K28_7};
      1: return {1'b1, `CODE_K28_1};
      2: return {1'b1, `CODE_K28_5};
      default: return 9'h000;
    endcase
  endfunction
  // compare outputs against the oldest note
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen)
      check("rdata", {1'b0, rdata}, {1'b0, exp_rd.pop_front()});
    if (cval === 1'b1)
      check("char", cout, exp_ch.size() ? exp_ch.pop_front() : 9'h1ff);
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    bus(0, `OFF_FRAME_CHAR, 8'h00);
    bus(0, `OFF_LINK_STATUS, 8'h04);
    // every select, set while disabled, then end chars
    for (int s = 0; s < 4; s++) begin
      bus(1, `OFF_LINK_CTRL, 8'h02);
      bus(1, `OFF_FRAME_CHAR, 8'(s));
      bus(1, `OFF_LINK_CTRL, 8'h03);
      bus(1, `OFF_FRAME_CHAR, 8'(~s));
      bus(0, `OFF_FRAME_CHAR, 8'(s));
      send(1, 1, eoc(s), 1);
      send(1, 0, 9'h000, 1);
      send(0, 1, 9'h000, 1);
    end
    // 64b/66b passes chars, disabled link sends none
    bus(1, `OFF_LINK_CTRL, 8'h00);
    bus(1, `OFF_FRAME_CHAR, 8'h01);
    bus(1, `OFF_LINK_CTRL, 8'h01);
    bus(0, `OFF_LINK_CTRL, 8'h01);
    #1 check("ctl", {en, c8}, 9'h2);
    send(1, 1, 9'h000, 1);
    bus(1, `OFF_LINK_CTRL, 8'h02);
    send(1, 1, 9'h000, 0);
    lup <= 1;
    bus(1, `OFF_LINK_CTRL, 8'h03);
    pulse(1, 1);
    bus(0, `OFF_LINK_STATUS, 8'h7c);
    bus(1, `OFF_LINK_STATUS, 8'h00);
    bus(0, `OFF_LINK_STATUS, 8'h7c);
    bus(1, `OFF_LINK_STATUS, 8'h18);
    bus(0, `OFF_LINK_STATUS, 8'h64);
    pulse(1, 0);
    bus(0, `OFF_LINK_STATUS, 8'h64);
    pll <= 0;
    hold <= 1;
    lup <= 0;
    repeat (4) @(posedge clk);
    bus(0, `OFF_LINK_STATUS, 8'h00);
    // interrupt raise, mask and clear
    bus(1, `OFF_IRQ_MASK, 8'h00);
    #1 check("irq", irq, 9'h0);
    bus(1, `OFF_IRQ_MASK, 8'h04);
    #1 check("irq", irq, 9'h1);
    bus(0, `OFF_IRQ_STATUS, 8'h1c);
    bus(1, `OFF_IRQ_STATUS, 8'h04);
    #1 check("irq", irq, 9'h0);
    bus(1, `OFF_IRQ_MASK, 8'h10);
    #1 check("irq", irq, 9'h1);
    bus(1, 10'h3ff, 8'hff);
    bus(0, 10'h3ff, 8'h00);
    repeat (2) @(posedge clk);
    check("left", 9'(exp_ch.size()), 9'h0);
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
